//--- core/dma_hub_defs.svh
`ifndef DMA_HUB_DEFS_SVH
`define DMA_HUB_DEFS_SVH
`define NUM_CH      24
`define NUM_TD      128
`define NUM_SPOKE   8
`define NUM_LVL     8
// Spoke select and descriptor window in hub addresses
`define SPK_MSB     31
`define SPK_LSB     29
`define WIN_MSB     31
`define WIN_LSB     16
`define WIN_TAG     16'h4000
`define IDX_MSB     10
`define IDX_LSB     4
`define WRD_MSB     3
`define WRD_LSB     2
// APB map
`define APB_TD_BIT  11
`define GLOBAL_CH   5'h1f
`define W_CFG       2'h0
`define W_CTL       2'h1
`define W_STAT      2'h2
`define TD_SRC      2'h0
`define TD_DST      2'h1
`define TD_LEN      2'h2
`define TD_CTL      2'h3
// Control word bits and arbiter priority levels
`define CTL_GO      0
`define CTL_STALL   1
`define CTL_CANCEL  2
`define FAIR_LVL    3'h2
`define MAX_LVL     3'h7
`endif

//--- core/dma_hub_pkg.sv
package dma_hub_pkg;
   typedef struct packed {
      logic [6:0] pad;
      logic [4:0] trigCh;
      logic       trigSel;
      logic [6:0] burst;
      logic [6:0] firstTd;
      logic       noRr;
      logic [2:0] prio;
      logic       enable;
   } chan_cfg_s;
   typedef struct packed {
      logic [16:0] pad;
      logic        dstInc;
      logic        srcInc;
      logic [1:0]  size;
      logic        unbounded;
      logic        irqChain;
      logic        irqTd;
      logic        nextValid;
      logic [6:0]  next;
   } td_ctl_s;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } bus_req_s;
   typedef struct packed {
      logic        ready;
      logic [31:0] rdata;
   } bus_rsp_s;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_FETCH = 4'h2,
      ST_BURST = 4'h4,
      ST_END   = 4'h8
   } state_e;
endpackage

//--- core/dma_hub_with_priority_arbiter.sv
`timescale 1ns/1ns
`include "dma_hub_defs.svh"
module dma_hub_with_priority_arbiter #(
   parameter int NUM_CH = `NUM_CH,
   parameter int NUM_TD = `NUM_TD
) (
   input  wire logic                 mclk,
   input  wire logic                 reset,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire dma_hub_pkg::bus_req_s cpuReq,
   output dma_hub_pkg::bus_rsp_s      cpuRsp,
   output dma_hub_pkg::bus_req_s      spokeReq [`NUM_SPOKE],
   input  wire dma_hub_pkg::bus_rsp_s spokeRsp [`NUM_SPOKE],
   input  wire logic [NUM_CH-1:0]    trigIn,
   output logic      [NUM_CH-1:0]    tdDoneIrq,
   output logic      [NUM_CH-1:0]    chainDoneIrq
);
   generate
      if (NUM_CH < 1 || NUM_CH > 31 || NUM_TD < 1 || NUM_TD > `NUM_TD) begin : g_bad
         $error("dma hub: unsupported channel or descriptor count");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [2:0] min3(input logic [2:0] a, input logic [16:0] b, input logic [6:0] c);
      logic [2:0] m;
      m = a;
      if (b < 17'(m)) m = b[2:0];
      if (c < 7'(m)) m = c[2:0];
      return m;
   endfunction
   function automatic logic inWin(input logic [31:0] a);
      return a[`WIN_MSB:`WIN_LSB] == `WIN_TAG;
   endfunction
   function automatic logic [8:0] poolIdx(input logic [31:0] a);
      return {a[`IDX_MSB:`IDX_LSB], a[`WRD_MSB:`WRD_LSB]};
   endfunction

   dma_hub_pkg::chan_cfg_s cfg     [NUM_CH];
   dma_hub_pkg::td_ctl_s   tdc     [NUM_CH];
   logic [31:0]            pool    [4*`NUM_TD];
   logic [31:0]            srcPtr  [NUM_CH];
   logic [31:0]            dstPtr  [NUM_CH];
   logic [16:0]            remain  [NUM_CH];
   logic [6:0]             curTd   [NUM_CH];
   logic [4:0]             rrPtr   [`NUM_LVL];
   logic [NUM_CH-1:0]      pend, stall, cancelReq, loaded, chanDone;
   logic [NUM_CH-1:0]      s1, s2, s3, filt, filtD;
   logic                   fairEn;
   logic [6:0]             gcnt;
   dma_hub_pkg::state_e    st;
   logic [4:0]             actCh;
   logic [6:0]             burstLeft;
   logic [31:0]            rdBuf, wrBuf;
   logic                   rdFull, wrFull;
   logic [2:0]             rdBytes, wrBytes;

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   wire        apbSetup = psel & ~penable;
   wire        apbWr    = psel & penable & pwrite;
   wire        tdSpace  = paddr[`APB_TD_BIT];
   wire [4:0]  apbCh    = paddr[8:4];
   wire [1:0]  apbWord  = paddr[`WRD_MSB:`WRD_LSB];
   wire [8:0]  apbIdx   = {paddr[`IDX_MSB:`IDX_LSB], apbWord};
   wire        isGlob   = ~tdSpace & apbCh == `GLOBAL_CH & apbWord == `W_CFG;
   wire        chOk     = ~tdSpace & 32'(apbCh) < NUM_CH & apbWord != `TD_CTL;
   wire        tdOk     = tdSpace & 32'(paddr[`IDX_MSB:`IDX_LSB]) < NUM_TD;
   wire        mapped   = isGlob | chOk | tdOk;
   wire        apbTdWr  = apbWr & tdOk;
   wire        ctlWr    = apbWr & chOk & apbWord == `W_CTL;
   wire [NUM_CH-1:0] ctlSel = ctlWr ? NUM_CH'(1) << apbCh : '0;
   wire [NUM_CH-1:0] cpuGo  = pwdata[`CTL_GO] ? ctlSel : '0;
   wire [NUM_CH-1:0] cxlHit = pwdata[`CTL_CANCEL] ? ctlSel : '0;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   logic [31:0] rdMux;
   always_comb begin
      rdMux = '0;
      if (tdOk) rdMux = pool[apbIdx];
      else if (isGlob) rdMux = {31'h0, fairEn};
      else if (chOk && apbWord == `W_CFG) rdMux = cfg[apbCh];
      else if (chOk && apbWord == `W_CTL) rdMux = {30'h0, stall[apbCh], 1'b0};
      else if (chOk) rdMux = {22'h0, curTd[apbCh], stall[apbCh], st != dma_hub_pkg::ST_IDLE && actCh == apbCh, pend[apbCh]};
   end
   always_ff @(posedge mclk) begin
      if (reset) prdata <= '0;
      else if (apbSetup) prdata <= rdMux;
   end

   ////////////////////////////////////////////////////////////////////////
   // Trigger inputs: three flops, change accepted when last two agree
   always_ff @(posedge mclk) begin
      if (reset) begin
         s1 <= '0; s2 <= '0; s3 <= '0; filt <= '0; filtD <= '0;
      end else begin
         s1 <= trigIn;
         s2 <= s1;
         s3 <= s2;
         filt <= (s2 & s3) | (filt & (s2 | s3));
         filtD <= filt;
      end
   end
   wire [NUM_CH-1:0] pinRise = filt & ~filtD;
   logic [NUM_CH-1:0] trig;
   always_comb begin
      for (int i = 0; i < NUM_CH; i++)
         trig[i] = cpuGo[i] | (cfg[i].trigSel ? chanDone[cfg[i].trigCh] : pinRise[i]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Arbiter
   logic [NUM_CH-1:0] req;
   logic [`NUM_LVL-1:0] lvlHas;
   logic [2:0] topLvl, boostLvl, winLvl;
   logic       grantOk, found;
   logic [4:0] grantCh, idx;
   always_comb begin
      lvlHas = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         req[i] = cfg[i].enable & pend[i] & ~stall[i];
         if (req[i]) lvlHas[cfg[i].prio] = 1'b1;
      end
      topLvl = `MAX_LVL;
      for (int l = `NUM_LVL - 1; l >= 0; l--)
         if (lvlHas[l]) topLvl = 3'(l);
      boostLvl = `MAX_LVL;
      for (int b = 4; b >= 0; b--)
         if (gcnt[b]) boostLvl = 3'(b) + `FAIR_LVL;
      winLvl = topLvl;
      if (fairEn && topLvl >= `FAIR_LVL && lvlHas[boostLvl]) winLvl = boostLvl;
      found = 1'b0;
      grantCh = '0;
      for (int i = 0; i < NUM_CH; i++)
         if (!found && req[i] && cfg[i].prio == winLvl && cfg[i].noRr) begin
            found = 1'b1;
            grantCh = 5'(i);
         end
      for (int k = 1; k <= NUM_CH; k++) begin
         idx = 5'((32'(rrPtr[winLvl]) + k) % NUM_CH);
         if (!found && req[idx] && cfg[idx].prio == winLvl) begin
            found = 1'b1;
            grantCh = idx;
         end
      end
      grantOk = found;
   end

   ////////////////////////////////////////////////////////////////////////
   // Engine datapath
   dma_hub_pkg::td_ctl_s ac;
   assign ac = tdc[actCh];
   wire        inBurst  = st == dma_hub_pkg::ST_BURST;
   wire        tdEnd    = ~ac.unbounded & remain[actCh] == '0;
   wire        stop     = burstLeft == '0 | tdEnd;
   wire [2:0]  beat     = ac.unbounded ? min3(3'(ac.size) + 3'h1, 17'h1_ffff, burstLeft)
                                       : min3(3'(ac.size) + 3'h1, remain[actCh], burstLeft);
   wire        rdOn     = inBurst & ~rdFull & ~stop;
   wire        rdLocal  = inWin(srcPtr[actCh]);
   wire        wrLocal  = inWin(dstPtr[actCh]);
   wire [2:0]  rdSpk    = srcPtr[actCh][`SPK_MSB:`SPK_LSB];
   wire [2:0]  wrSpk    = dstPtr[actCh][`SPK_MSB:`SPK_LSB];
   wire [2:0]  cpuSpk   = cpuReq.addr[`SPK_MSB:`SPK_LSB];
   logic [`NUM_SPOKE-1:0] rdGo, wrGo;
   generate
      for (genvar s = 0; s < `NUM_SPOKE; s++) begin : g_spoke
         wire cpuHit = cpuReq.valid & cpuSpk == 3'(s);
         wire wrHit  = wrFull & ~wrLocal & wrSpk == 3'(s);
         wire rdHit  = rdOn & ~rdLocal & rdSpk == 3'(s) & ~wrHit;
         assign spokeReq[s] = cpuHit ? cpuReq
                            : wrHit ? {1'b1, 1'b1, 2'(wrBytes - 3'h1), dstPtr[actCh], wrBuf}
                            : rdHit ? {1'b1, 1'b0, 2'(beat - 3'h1), srcPtr[actCh], 32'h0}
                            : '0;
         assign wrGo[s] = wrHit & ~cpuHit & spokeRsp[s].ready;
         assign rdGo[s] = rdHit & ~cpuHit & spokeRsp[s].ready;
      end
   endgenerate
   assign cpuRsp = {cpuReq.valid & spokeRsp[cpuSpk].ready, spokeRsp[cpuSpk].rdata};
   wire        rdDone  = rdOn & (rdLocal | |rdGo);
   wire        wrDone  = wrFull & (wrLocal ? ~apbTdWr : |wrGo);
   wire        moveBuf = rdFull & (~wrFull | wrDone);
   wire [31:0] rdData  = rdLocal ? pool[poolIdx(srcPtr[actCh])] : spokeRsp[rdSpk].rdata;
   wire        drained = inBurst & stop & ~rdFull & ~wrFull;

   ////////////////////////////////////////////////////////////////////////
   // Descriptor pool, reachable by APB and by transfers into the window
   always_ff @(posedge mclk) begin
      if (apbTdWr) pool[apbIdx] <= pwdata;
      else if (wrDone && wrLocal) pool[poolIdx(dstPtr[actCh])] <= wrBuf;
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < NUM_CH; i++) cfg[i] <= '0;
         stall <= '0;
         fairEn <= 1'b0;
      end else if (apbWr && isGlob) begin
         fairEn <= pwdata[0];
      end else if (apbWr && chOk && apbWord == `W_CFG) begin
         cfg[apbCh] <= pwdata;
      end else if (ctlWr) begin
         stall[apbCh] <= pwdata[`CTL_STALL];
      end
   end

   // End-of-burst decisions for the active channel
   wire              atEnd    = st == dma_hub_pkg::ST_END;
   wire              cxlAct   = atEnd & cancelReq[actCh];
   wire              tdFin    = atEnd & ~cancelReq[actCh] & tdEnd;
   wire              chainEnd = tdFin & ~ac.nextValid;
   wire [NUM_CH-1:0] actSel   = NUM_CH'(1) << actCh;
   wire [NUM_CH-1:0] busyMask = st == dma_hub_pkg::ST_IDLE ? '0 : actSel;
   wire [NUM_CH-1:0] cxlNow   = cxlHit & ~busyMask;
   wire [NUM_CH-1:0] endClr   = (cxlAct | chainEnd) ? actSel : '0;
   wire [NUM_CH-1:0] start    = trig & ~pend & ~loaded & ~busyMask;

   always_ff @(posedge mclk) begin
      if (reset) begin
         pend <= '0;
         cancelReq <= '0;
         tdDoneIrq <= '0;
         chainDoneIrq <= '0;
         chanDone <= '0;
      end else begin
         pend <= trig | (pend & ~endClr & ~cxlNow);
         cancelReq <= (cancelReq | (cxlHit & busyMask)) & ~(cxlAct ? actSel : '0);
         tdDoneIrq <= (tdFin & ac.irqTd) ? actSel : '0;
         chainDoneIrq <= (chainEnd & ac.irqChain) ? actSel : '0;
         chanDone <= chainEnd ? actSel : '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         loaded <= '0;
         for (int i = 0; i < NUM_CH; i++) curTd[i] <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++)
            if (start[i]) curTd[i] <= cfg[i].firstTd;
         if (tdFin && ac.nextValid) curTd[actCh] <= ac.next;
         loaded <= (loaded | (st == dma_hub_pkg::ST_FETCH ? actSel : '0))
                   & ~cxlNow & ~((cxlAct | tdFin) ? actSel : '0);
      end
   end

   // Fetch loads a descriptor only when the channel holds none
   wire [8:0] fIdx = {curTd[actCh], 2'h0};
   always_ff @(posedge mclk) begin
      if (st == dma_hub_pkg::ST_FETCH && !loaded[actCh]) begin
         srcPtr[actCh] <= pool[fIdx + 9'(`TD_SRC)];
         dstPtr[actCh] <= pool[fIdx + 9'(`TD_DST)];
         remain[actCh] <= 17'(pool[fIdx + 9'(`TD_LEN)][15:0]) + 17'h1;
         tdc[actCh] <= pool[fIdx + 9'(`TD_CTL)];
      end else begin
         if (rdDone) begin
            if (ac.srcInc) srcPtr[actCh] <= srcPtr[actCh] + 32'(beat);
            if (!ac.unbounded) remain[actCh] <= remain[actCh] - 17'(beat);
         end
         if (wrDone && ac.dstInc) dstPtr[actCh] <= dstPtr[actCh] + 32'(wrBytes);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Beat buffers: read stage feeds write stage so both can overlap
   always_ff @(posedge mclk) begin
      if (reset) begin
         rdFull <= 1'b0;
         wrFull <= 1'b0;
         rdBuf <= '0;
         wrBuf <= '0;
         rdBytes <= '0;
         wrBytes <= '0;
      end else begin
         if (rdDone) begin
            rdBuf <= rdData;
            rdBytes <= beat;
         end
         rdFull <= rdDone | (rdFull & ~moveBuf);
         if (moveBuf) begin
            wrBuf <= rdBuf;
            wrBytes <= rdBytes;
         end
         wrFull <= moveBuf | (wrFull & ~wrDone);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel sequencer
   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= dma_hub_pkg::ST_IDLE;
         actCh <= '0;
         burstLeft <= '0;
         gcnt <= '0;
         for (int l = 0; l < `NUM_LVL; l++) rrPtr[l] <= '0;
      end else begin
         case (st)
            dma_hub_pkg::ST_IDLE: begin
               if (grantOk) begin
                  actCh <= grantCh;
                  rrPtr[winLvl] <= grantCh;
                  gcnt <= gcnt + 7'h1;
                  st <= dma_hub_pkg::ST_FETCH;
               end
            end
            dma_hub_pkg::ST_FETCH: begin
               burstLeft <= cfg[actCh].burst == '0 ? 7'h1 : cfg[actCh].burst;
               st <= dma_hub_pkg::ST_BURST;
            end
            dma_hub_pkg::ST_BURST: begin
               if (rdDone) burstLeft <= burstLeft - 7'(beat);
               if (drained) st <= dma_hub_pkg::ST_END;
            end
            dma_hub_pkg::ST_END: begin
               st <= dma_hub_pkg::ST_IDLE;
            end
            default: st <= dma_hub_pkg::ST_IDLE;
         endcase
      end
   end
endmodule

//--- verif/dma_hub_props.sv
`timescale 1ns/1ns
`include "dma_hub_defs.svh"
module dma_hub_props #(
   parameter int NUM_CH = 24
) (
   input wire logic                  mclk,
   input wire logic                  reset,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire dma_hub_pkg::bus_req_s cpuReq,
   input wire dma_hub_pkg::bus_rsp_s cpuRsp,
   input wire dma_hub_pkg::bus_req_s spokeReq [`NUM_SPOKE],
   input wire dma_hub_pkg::bus_rsp_s spokeRsp [`NUM_SPOKE],
   input wire logic [NUM_CH-1:0]     tdDoneIrq,
   input wire logic [NUM_CH-1:0]     chainDoneIrq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   wire logic [2:0] cpuSpk = cpuReq.addr[31:29];
   wire logic       cpuExt = cpuReq.valid && (cpuReq.addr[31:16] != `WIN_TAG);
   ///////////////////////////////////////////////
   property p_err_phase;
      pslverr |-> psel && penable;
   endproperty
   a_err_phase: assert property (p_err_phase)
      else $error("slave error outside access phase");
   property p_prdata_hold;
      psel && penable |-> pready ##1 $stable(prdata);
   endproperty
   a_prdata_hold: assert property (p_prdata_hold)
      else $error("read data moved in access phase");
   property p_cpu_rdy;
      cpuExt |-> cpuRsp.ready == spokeRsp[cpuSpk].ready;
   endproperty
   a_cpu_rdy: assert property (p_cpu_rdy)
      else $error("processor ready not from its spoke");
   property p_cpu_data;
      cpuExt && cpuRsp.ready |-> cpuRsp.rdata == spokeRsp[cpuSpk].rdata;
   endproperty
   a_cpu_data: assert property (p_cpu_data)
      else $error("processor read data not from its spoke");
   property p_cpu_first;
      cpuExt |-> spokeReq[cpuSpk] == cpuReq;
   endproperty
   a_cpu_first: assert property (p_cpu_first)
      else $error("processor did not win its spoke");
   for (genvar s = 0; s < `NUM_SPOKE; s++) begin : g_spk
      wire logic cpuHere = cpuExt && (cpuSpk == s);
      property p_dma_hold;
         spokeReq[s].valid && !spokeRsp[s].ready && !cpuHere ##1 !cpuHere |-> $stable(spokeReq[s]);
      endproperty
      a_dma_hold: assert property (p_dma_hold)
         else $error("pending spoke request changed before ready");
      property p_no_win;
         spokeReq[s].valid && !cpuHere |-> spokeReq[s].addr[31:16] != `WIN_TAG;
      endproperty
      a_no_win: assert property (p_no_win)
         else $error("descriptor window access leaked to spoke");
   end
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      property p_td_pulse;
         tdDoneIrq[i] |=> !tdDoneIrq[i] [*3];
      endproperty
      a_td_pulse: assert property (p_td_pulse)
         else $error("descriptor done pulse too long or too close");
      property p_chain_pulse;
         chainDoneIrq[i] |=> !chainDoneIrq[i] [*3];
      endproperty
      a_chain_pulse: assert property (p_chain_pulse)
         else $error("chain done pulse too long or too close");
   end
   c_td: cover property (|tdDoneIrq);
   c_chain: cover property (|chainDoneIrq);
   c_cpu_wait: cover property (cpuExt && !cpuRsp.ready);
   c_share: cover property (cpuExt && cpuSpk != 3'h0 && spokeReq[0].valid);
endmodule

//--- verif/hub_spoke_model.sv
`timescale 1ns/1ns
`include "dma_hub_defs.svh"
module hub_spoke_model (
   input  wire logic                  mclk,
   input  wire logic                  slow,
   input  wire dma_hub_pkg::bus_req_s spokeReq [`NUM_SPOKE],
   output dma_hub_pkg::bus_rsp_s      spokeRsp [`NUM_SPOKE]
);
   logic [31:0] mem [logic [31:0]];
   // Unwritten words read back a pattern derived from the address
   function automatic logic [31:0] peek(input logic [31:0] a);
      logic [31:0] k;
      k = {a[31:2], 2'b00};
      return mem.exists(k) ? mem[k] : k ^ 32'hA5A5_A5A5;
   endfunction
   for (genvar s = 0; s < `NUM_SPOKE; s++) begin : g_spk
      logic [1:0]  waited = 2'h0;
      logic [31:0] lastData = 32'h0000_0000;
      wire logic   rdy = spokeReq[s].valid && (!slow || waited == 2'h2);
      wire logic [31:0] msk = 32'hFFFF_FFFF >> (8 * (3 - spokeReq[s].size));
      wire logic [31:0] dat = rdy ? peek(spokeReq[s].addr) : ~lastData;
      assign spokeRsp[s] = '{rdy, dat};
      always @(posedge mclk) begin
         waited <= (spokeReq[s].valid && !rdy) ? waited + 2'h1 : 2'h0;
         if (rdy) begin
            lastData <= dat;
            if (spokeReq[s].write)
               mem[{spokeReq[s].addr[31:2], 2'b00}] = (dat & ~msk) | (spokeReq[s].wdata & msk);
         end
      end
   end
endmodule

//--- verif/test_dma_hub_with_priority_arbiter.sv
`timescale 1ns/1ns
`include "dma_hub_defs.svh"
module test_dma_hub_with_priority_arbiter;
   localparam logic [31:0] PAT = 32'hA5A5_A5A5;
   logic                  mclk;
   logic                  reset;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [11:0]           paddr;
   logic [31:0]           pwdata;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic                  slow;
   dma_hub_pkg::bus_req_s cpuReq;
   dma_hub_pkg::bus_rsp_s cpuRsp;
   dma_hub_pkg::bus_req_s spokeReq [`NUM_SPOKE];
   dma_hub_pkg::bus_rsp_s spokeRsp [`NUM_SPOKE];
   logic [23:0]           trigIn;
   logic [23:0]           tdDoneIrq;
   logic [23:0]           chainDoneIrq;
   int                    miscompares = 0;
   int                    check_count = 0;
   int                    tdCnt [24] = '{default: 0};
   int                    chCnt [24] = '{default: 0};
   int                    doneQ [$];
   logic [15:0]           rnd = 16'h0030;
   logic [31:0]           rd;
   logic                  err;
   dma_hub_with_priority_arbiter #(.NUM_CH(24), .NUM_TD(128)) DUT (.mclk(mclk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq), .cpuRsp(cpuRsp), .spokeReq(spokeReq),
      .spokeRsp(spokeRsp), .trigIn(trigIn), .tdDoneIrq(tdDoneIrq), .chainDoneIrq(chainDoneIrq));
   hub_spoke_model sp (.mclk(mclk), .slow(slow), .spokeReq(spokeReq), .spokeRsp(spokeRsp));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
      for (int i = 0; i < 24; i++) begin
         if (tdDoneIrq[i] === 1'b1)
            tdCnt[i]++;
         if (chainDoneIrq[i] === 1'b1) begin
            chCnt[i]++;
            doneQ.push_back(i);
         end
      end
   ///////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] cfgw(input logic [2:0] p, input logic [6:0] f, b, input logic t,
                                        input logic [4:0] c);
      return {7'h00, c, t, b, f, 1'b0, p, 1'b1};
   endfunction
   function automatic logic [31:0] tdc(input logic ic, it, nv, input logic [6:0] nx);
      return {17'h0_0000, 1'b1, 1'b1, 2'h3, 1'b0, ic, it, nv, nx};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic td(input int i, input logic [31:0] s, d, input logic [15:0] l, input logic [31:0] c);
      logic [11:0] b;
      b = 12'(12'h800 + i * 16);
      apb(1'b1, b, s);
      apb(1'b1, b + 12'h004, d);
      apb(1'b1, b + 12'h008, {16'h0000, l});
      apb(1'b1, b + 12'h00C, c);
   endtask
   task automatic cpu_rd(input logic [31:0] a);
      @(posedge mclk);
      cpuReq <= '{1'b1, 1'b0, 2'h3, a, 32'h0000_0000};
      @(posedge mclk);
      for (int k = 0; k < 100 && cpuRsp.ready !== 1'b1; k++)
         @(posedge mclk);
      chk(cpuRsp.rdata, a ^ PAT);
      cpuReq.valid <= 1'b0;
   endtask
   task automatic wait_chain(input int ch, input int n);
      for (int k = 0; k < 3000 && chCnt[ch] < n; k++)
         @(posedge mclk);
      chk(32'(chCnt[ch]), 32'(n));
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ///////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      $display("Error at %0t: run did not finish", $time);
      wrap_up();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, slow, trigIn} = '0;
      cpuReq = '0;
      reset = 1'b1;
      sp.mem[32'h0000_0200] = 32'h0000_0300;
      sp.mem[32'h0000_0300] = {rnd, ~rnd};
      sp.mem[32'h0000_0304] = {~rnd, rnd};
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b1, 12'h170, cfgw(3'h6, 7'h7F, 7'h7F, 1'b1, 5'h16) - 32'h0000_0001);
      apb(1'b0, 12'h170, 32'h0000_0000);
      chk(rd, cfgw(3'h6, 7'h7F, 7'h7F, 1'b1, 5'h16) - 32'h0000_0001);
      apb(1'b0, 12'h17C, 32'h0000_0000);
      chk({rd[30:0], err}, 32'h0000_0001);
      apb(1'b1, 12'h1F0, 32'h0000_0001);
      apb(1'b0, 12'h1F0, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      apb(1'b1, 12'h1F0, 32'h0000_0000);
      $display("test registers done");
      // First descriptor patches the second one's source before it is fetched
      td(0, 32'h0000_0200, 32'h4000_0010, 16'h0003, tdc(1'b0, 1'b1, 1'b1, 7'h01));
      td(1, 32'h0000_0F00, 32'h2000_0000, 16'h0005, tdc(1'b1, 1'b0, 1'b0, 7'h00));
      apb(1'b1, 12'h000, cfgw(3'h0, 7'h00, 7'h04, 1'b0, 5'h00));
      slow <= 1'b1;
      fork
         apb(1'b1, 12'h004, 32'h0000_0001);
         repeat (6) begin
            rnd = lfsr(rnd);
            cpu_rd({rnd[0] ? 3'h4 : 3'h0, 17'h0_0001, rnd[11:2], 2'b00});
         end
      join
      wait_chain(0, 1);
      chk(32'(tdCnt[0]), 32'h0000_0001);
      chk(sp.peek(32'h2000_0000), sp.mem[32'h0000_0300]);
      chk(sp.peek(32'h2000_0004), (32'h2000_0004 ^ PAT) & 32'hFFFF_0000 | sp.mem[32'h0000_0304] & 32'h0000_FFFF);
      apb(1'b0, 12'h810, 32'h0000_0000);
      chk(rd, 32'h0000_0300);
      $display("test nested chain done");
      slow <= 1'b0;
      doneQ.delete();
      td(2, 32'h0000_0400, 32'h6000_0000, 16'h0003, tdc(1'b1, 1'b0, 1'b0, 7'h00));
      td(3, 32'h0000_0404, 32'h6000_0010, 16'h0003, tdc(1'b1, 1'b0, 1'b0, 7'h00));
      apb(1'b1, 12'h030, cfgw(3'h5, 7'h02, 7'h04, 1'b0, 5'h00));
      apb(1'b1, 12'h040, cfgw(3'h1, 7'h03, 7'h04, 1'b0, 5'h00));
      rnd = lfsr(rnd);
      @(posedge mclk);
      // Random noise on disabled upper channels
      trigIn <= {rnd[7:0], 16'h0018};
      repeat (6) @(posedge mclk);
      trigIn <= 24'h00_0000;
      wait_chain(3, 1);
      chk(32'(doneQ[0]), 32'h0000_0004);
      for (int j = 0; j < 2; j++)
         chk(sp.peek(32'h6000_0000 + 32'(j * 16)), (32'h0000_0400 + 32'(j * 4)) ^ PAT);
      $display("test priority done");
      doneQ.delete();
      td(4, 32'h0000_0500, 32'hA000_0000, 16'h0007, tdc(1'b1, 1'b0, 1'b0, 7'h00));
      td(5, 32'h0000_0508, 32'hA000_0010, 16'h0003, tdc(1'b1, 1'b0, 1'b0, 7'h00));
      apb(1'b1, 12'h020, cfgw(3'h2, 7'h05, 7'h7F, 1'b1, 5'h01));
      apb(1'b1, 12'h010, cfgw(3'h2, 7'h04, 7'h04, 1'b0, 5'h00));
      @(posedge mclk);
      trigIn <= 24'h00_0002;
      repeat (6) @(posedge mclk);
      trigIn <= 24'h00_0000;
      wait_chain(2, 1);
      chk(32'(doneQ[0]), 32'h0000_0001);
      chk(sp.peek(32'hA000_0004), 32'h0000_0504 ^ PAT);
      $display("test chained trigger done");
      td(6, 32'h0000_0600, 32'hC000_0000, 16'h0003, tdc(1'b1, 1'b0, 1'b0, 7'h00));
      apb(1'b1, 12'h050, cfgw(3'h3, 7'h06, 7'h04, 1'b0, 5'h00));
      apb(1'b1, 12'h054, 32'h0000_0003);
      repeat (40) @(posedge mclk);
      apb(1'b0, 12'h058, 32'h0000_0000);
      chk(32'({rd[2], rd[0]}), 32'h0000_0003);
      apb(1'b1, 12'h054, 32'h0000_0004);
      repeat (40) @(posedge mclk);
      apb(1'b0, 12'h058, 32'h0000_0000);
      chk(32'(rd[0]), 32'h0000_0000);
      chk(32'(chCnt[5]), 32'h0000_0000);
      chk(sp.peek(32'hC000_0000), 32'hC000_0000 ^ PAT);
      $display("test stall and cancel done");
      wrap_up();
   end
endmodule
bind dma_hub_with_priority_arbiter dma_hub_props #(.NUM_CH(NUM_CH)) u_props (.mclk(mclk), .reset(reset),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq),
   .cpuRsp(cpuRsp), .spokeReq(spokeReq), .spokeRsp(spokeRsp), .tdDoneIrq(tdDoneIrq),
   .chainDoneIrq(chainDoneIrq));
